//--- lsd_map.svh
// Purpose: offsets, field positions and timing counts for the status display update logic
// Assumes: 100 MHz clock
// Notes: definitions only
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH

// ****************************************
// timing
// ****************************************
`define LSD_CLK_MHZ 100
`define LSD_LED_TEST_MS 1000
`define LSD_FREEZE_MS 30
`define LSD_LED_TEST_CYCLES (`LSD_LED_TEST_MS * 1000 * `LSD_CLK_MHZ)
`define LSD_FREEZE_CYCLES (`LSD_FREEZE_MS * 1000 * `LSD_CLK_MHZ)
`define LSD_SETUP_CYCLES 3
`define LSD_STROBE_CYCLES 2
`define LSD_HOLD_CYCLES 2

// ****************************************
// data line positions
// ****************************************
`define LSD_D_LINK 0
`define LSD_D_COL 1
`define LSD_D_REC 2
`define LSD_D_JABPART 3
`define LSD_D_POL 4
`define LSD_D_ADDR_LSB 5
`define LSD_D_ADDR_MSB 7

// ****************************************
// slots and masks
// ****************************************
`define LSD_SLOT_LAST 4'hd
`define LSD_MIN_USED_MASK 5'h1e
`define LSD_MAX_USED_MASK 5'h1f
`define LSD_SLOT0_MAX_MASK 5'h0e

`endif

//--- lsd_pkg.sv
// Purpose: types shared by the status display update logic
// Assumes: nothing
// Notes: constants live in lsd_map.svh
package lsd_pkg;
  typedef logic [13:1] lsd_port_vec_t;
  typedef logic [4:0] lsd_stat_t;
  typedef logic [3:0] lsd_slot_t;
  typedef enum logic [1:0] {
    LSD_ST_IDLE = 2'b00,
    LSD_ST_SETUP = 2'b01,
    LSD_ST_STROBE = 2'b10,
    LSD_ST_HOLD = 2'b11
  } lsd_state_e;
endpackage

//--- lsd_stat_mem.sv
// Purpose: per-slot status snapshot store, 16 words of 5 bits
// Assumes: one write and one read port, same clock
// Notes: read data come from a register, one cycle after the address
`timescale 1ns/1ns
module lsd_stat_mem (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire lsd_pkg::lsd_slot_t wr_addr,
  input wire lsd_pkg::lsd_stat_t wr_data,
  input wire lsd_pkg::lsd_slot_t rd_addr,
  output lsd_pkg::lsd_stat_t rd_data
);
  import lsd_pkg::*;

  lsd_stat_t mem [0:15];
  lsd_stat_t rd_reg;

  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_reg;
endmodule // lsd_stat_mem

//--- lsd_display.sv
// Purpose: autonomous status display update for a multiport repeater
// Assumes: status inputs synchronous to clk; strobes drive external latches
// Notes: strobes idle high and pulse low while latches load
`timescale 1ns/1ns
`include "lsd_map.svh"
module lsd_display #(
  parameter int unsigned LED_TEST_CYCLES = `LSD_LED_TEST_CYCLES,
  parameter int unsigned FREEZE_CYCLES = `LSD_FREEZE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic mode_load_n,
  input wire logic mode_cfg_max,
  input wire logic realtime_interrupt,
  input wire logic repeat_active,
  input wire logic jabber_active,
  input wire lsd_pkg::lsd_port_vec_t port_link,
  input wire lsd_pkg::lsd_port_vec_t port_col,
  input wire lsd_pkg::lsd_port_vec_t port_rec,
  input wire lsd_pkg::lsd_port_vec_t port_part,
  input wire lsd_pkg::lsd_port_vec_t port_bad_pol,
  input wire lsd_pkg::lsd_port_vec_t port_internal_tp,
  output logic [7:0] disp_data,
  output logic strobe_low_group,
  output logic strobe_high_group,
  output logic repeat_inhibit,
  output logic led_test_active
);
  import lsd_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic slot_is_high(input lsd_slot_t s);
    slot_is_high = s[3];
  endfunction

  function automatic lsd_slot_t slot_step(input lsd_slot_t s);
    if (s >= `LSD_SLOT_LAST) begin
      slot_step = 4'h0;
    end else begin
      slot_step = s + 4'h1;
    end
  endfunction

  // upper latches hold ports 8 to 13 and only exist in maximum mode
  function automatic logic use_high_group(input logic max_mode, input lsd_slot_t s);
    use_high_group = max_mode && slot_is_high(s);
  endfunction

  // maximum mode tags the word with its latch address
  function automatic logic [7:0] pin_word(input logic max_mode, input lsd_slot_t s, input lsd_stat_t w);
    if (max_mode) begin
      pin_word = {s[2:0], w};
    end else begin
      // minimum: col D1, rec D2, jab D3, part D4, rest idle low
      pin_word = {3'b000, w};
    end
  endfunction

  // ****************************************
  // live status per slot
  // ****************************************
  lsd_stat_t live_slot [0:15];

  // slot 0 carries the summary flags; the summary partition bit rides in
  // the polarity position so minimum mode can read it from the same word
  assign live_slot[0] = {|port_part, jabber_active, |port_rec, |port_col, 1'b0};
  assign live_slot[14] = 5'h00;
  assign live_slot[15] = 5'h00;

  genvar gi;
  generate
    for (gi = 1; gi <= 13; gi++) begin : g_slot
      // link and polarity only mean something on internal twisted pair
      assign live_slot[gi] = {port_bad_pol[gi] & port_internal_tp[gi],
                              port_part[gi],
                              port_rec[gi],
                              port_col[gi],
                              port_link[gi] & port_internal_tp[gi]};
    end
  endgenerate

  // ****************************************
  // mode capture and indicator test
  // ****************************************
  logic max_mode_reg, max_mode_next;
  logic mode_load_n_prev_reg, mode_load_n_prev_next;
  logic test_active_reg, test_active_next;
  logic [31:0] test_cnt_reg, test_cnt_next;

  always_comb begin
    max_mode_next = max_mode_reg;
    mode_load_n_prev_next = mode_load_n;
    test_active_next = test_active_reg;
    test_cnt_next = test_cnt_reg;
    // mode bit follows the pin for as long as mode load is held low
    if (!mode_load_n) begin
      max_mode_next = mode_cfg_max;
      test_active_next = 1'b0;
      test_cnt_next = 32'h0;
    end else if (!mode_load_n_prev_reg) begin
      test_active_next = 1'b1;
      test_cnt_next = 32'h0;
    end else if (test_active_reg) begin
      if (test_cnt_reg >= LED_TEST_CYCLES - 1) begin
        test_active_next = 1'b0;
      end else begin
        test_cnt_next = test_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      max_mode_reg <= 1'b0;
      mode_load_n_prev_reg <= 1'b1;
      test_active_reg <= 1'b0;
      test_cnt_reg <= 32'h0;
    end else if (ce) begin
      max_mode_reg <= max_mode_next;
      mode_load_n_prev_reg <= mode_load_n_prev_next;
      test_active_reg <= test_active_next;
      test_cnt_reg <= test_cnt_next;
    end
  end

  // repetition is held off during the test
  assign repeat_inhibit = test_active_reg;
  assign led_test_active = test_active_reg;

  // ****************************************
  // activity stretch
  // ****************************************
  logic rep_prev_reg, rep_prev_next;
  logic frozen_reg, frozen_next;
  logic [31:0] freeze_cnt_reg, freeze_cnt_next;

  always_comb begin
    rep_prev_next = repeat_active;
    frozen_next = frozen_reg;
    freeze_cnt_next = freeze_cnt_reg;
    if (repeat_active) begin
      frozen_next = 1'b0;
      freeze_cnt_next = 32'h0;
    end else if (rep_prev_reg) begin
      frozen_next = 1'b1;
      freeze_cnt_next = 32'h0;
    end else if (frozen_reg) begin
      if (freeze_cnt_reg >= FREEZE_CYCLES - 1) begin
        frozen_next = 1'b0;
      end else begin
        freeze_cnt_next = freeze_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rep_prev_reg <= 1'b0;
      frozen_reg <= 1'b0;
      freeze_cnt_reg <= 32'h0;
    end else if (ce) begin
      rep_prev_reg <= rep_prev_next;
      frozen_reg <= frozen_next;
      freeze_cnt_reg <= freeze_cnt_next;
    end
  end

  // ****************************************
  // snapshot writer
  // ****************************************
  lsd_slot_t wr_slot_reg, wr_slot_next;
  logic snap_we;

  // the falling edge of activity is seen one cycle late, so the last
  // live word written is the one present as the packet ended
  assign snap_we = !frozen_reg && !rep_prev_reg ? 1'b1 : !frozen_reg;

  always_comb begin
    wr_slot_next = slot_step(wr_slot_reg);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_slot_reg <= 4'h0;
    end else if (ce) begin
      wr_slot_reg <= wr_slot_next;
    end
  end

  lsd_slot_t rd_slot;
  lsd_stat_t rd_stat;

  lsd_stat_mem u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(snap_we),
    .wr_addr(wr_slot_reg),
    .wr_data(live_slot[wr_slot_reg]),
    .rd_addr(rd_slot),
    .rd_data(rd_stat)
  );

  // ****************************************
  // display scanner
  // ****************************************
  // one slot: idle, three setup, two strobe and two hold phases
  lsd_state_e state_reg, state_next;
  lsd_slot_t slot_reg, slot_next;
  logic [1:0] phase_reg, phase_next;
  lsd_stat_t shown;

  assign rd_slot = slot_reg;

  // test forces every used line on, otherwise the snapshot word
  always_comb begin
    if (!max_mode_reg) begin
      shown = test_active_reg ? `LSD_MIN_USED_MASK : (rd_stat & `LSD_MIN_USED_MASK);
    end else if (slot_reg == 4'h0) begin
      shown = test_active_reg ? `LSD_SLOT0_MAX_MASK : (rd_stat & `LSD_SLOT0_MAX_MASK);
    end else begin
      shown = test_active_reg ? `LSD_MAX_USED_MASK : rd_stat;
    end
  end

  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    phase_next = phase_reg;
    case (state_reg)
      LSD_ST_IDLE: begin
        phase_next = 2'h0;
        // checked only here, so a slot already in flight completes
        if (!realtime_interrupt) begin
          state_next = LSD_ST_SETUP;
        end
      end
      LSD_ST_SETUP: begin
        phase_next = phase_reg + 2'h1;
        if (phase_reg == 2'(`LSD_SETUP_CYCLES - 1)) begin
          state_next = LSD_ST_STROBE;
          phase_next = 2'h0;
        end
      end
      LSD_ST_STROBE: begin
        phase_next = phase_reg + 2'h1;
        if (phase_reg == 2'(`LSD_STROBE_CYCLES - 1)) begin
          state_next = LSD_ST_HOLD;
          phase_next = 2'h0;
        end
      end
      LSD_ST_HOLD: begin
        // word stays put through hold, past the strobe's rising edge
        phase_next = phase_reg + 2'h1;
        if (phase_reg == 2'(`LSD_HOLD_CYCLES - 1)) begin
          state_next = LSD_ST_IDLE;
          phase_next = 2'h0;
          slot_next = max_mode_reg ? slot_step(slot_reg) : 4'h0;
        end
      end
      default: begin
        state_next = LSD_ST_IDLE;
        phase_next = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= LSD_ST_IDLE;
      slot_reg <= 4'h0;
      phase_reg <= 2'h0;
    end else if (ce) begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      phase_reg <= phase_next;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic [7:0] data_reg, data_next;
  logic strl_reg, strl_next;
  logic strh_reg, strh_next;
  logic load_word;
  logic strobe_due;

  // word settles a full phase before the latch opens
  assign load_word = (state_reg == LSD_ST_SETUP) && (phase_reg == 2'h1);
  // strobe follows the next state, so it spans exactly the strobe phases
  assign strobe_due = (state_next == LSD_ST_STROBE);

  // word only moves in setup, never under a strobe
  always_comb begin
    data_next = data_reg;
    if (load_word) begin
      data_next = pin_word(max_mode_reg, slot_reg, shown);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_reg <= 8'h00;
    end else if (ce) begin
      data_reg <= data_next;
    end
  end

  // minimum mode never selects the high group, so that strobe rests at one
  always_comb begin
    strl_next = 1'b1;
    strh_next = 1'b1;
    if (strobe_due) begin
      if (use_high_group(max_mode_reg, slot_reg)) begin
        strh_next = 1'b0;
      end else begin
        strl_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      strl_reg <= 1'b1;
      strh_reg <= 1'b1;
    end else if (ce) begin
      strl_reg <= strl_next;
      strh_reg <= strh_next;
    end
  end

  // registered pins, so no combinational glitch can open a latch
  assign disp_data = data_reg;
  assign strobe_low_group = strl_reg;
  // high strobe never pulses in minimum mode, so it stays at one
  assign strobe_high_group = strh_reg;
endmodule // lsd_display

//--- lsd_display_assertions.sv
// Purpose: concurrent checks on the status display update ports
// Assumes: ce held high while a test period is being counted
// Notes: mode bit tracked here from mode_load_n, as the design captures it
`timescale 1ns/1ns
module lsd_display_assertions #(
  parameter int unsigned LED_TEST_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic mode_load_n,
  input wire logic mode_cfg_max,
  input wire logic realtime_interrupt,
  input wire logic [7:0] disp_data,
  input wire logic strobe_low_group,
  input wire logic strobe_high_group,
  input wire logic repeat_inhibit,
  input wire logic led_test_active
);
  logic max_reg, max_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [4:0] settle_reg, settle_next;
  logic settled;
  always_comb begin
    max_next = mode_load_n ? max_reg : mode_cfg_max;
    cnt_next = !led_test_active ? 32'h0 : cnt_reg + {31'h0, ce};
    // slot in flight at a mode change may still show old data
    settle_next = !mode_load_n ? 5'h0 : settle_reg + {4'h0, settle_reg != 5'h1f};
    if (!rstn) begin
      max_next = 1'b0;
      cnt_next = 32'h0;
      settle_next = 5'h0;
    end
  end
  always_ff @(posedge clk) begin
    max_reg <= max_next;
    cnt_reg <= cnt_next;
    settle_reg <= settle_next;
  end
  assign settled = settle_reg == 5'h1f;
  default clocking @(posedge clk); endclocking
  // a low clock enable stretches every phase, so checks pause meanwhile
  default disable iff (!rstn || !ce);
  // ****************************************
  // properties
  // ****************************************
  sequence s_pulse_low;
    !strobe_low_group ##1 !strobe_low_group ##1 strobe_low_group;
  endsequence
  sequence s_rti_held;
    realtime_interrupt [*8] ##1 realtime_interrupt [*4];
  endsequence
  property p_low_pulse; $fell(strobe_low_group) |-> s_pulse_low; endproperty
  a_low_pulse: assert property (p_low_pulse) else $error("low strobe width wrong");
  property p_stable; (!strobe_low_group || !strobe_high_group) |-> $stable(disp_data); endproperty
  a_stable: assert property (p_stable) else $error("data moved under strobe");
  property p_high_slots; $fell(strobe_high_group) |-> max_reg && disp_data[7:5] <= 3'h5; endproperty
  a_high_slots: assert property (p_high_slots) else $error("bad high group load");
  property p_min_high; (settled && !max_reg) |-> strobe_high_group; endproperty
  a_min_high: assert property (p_min_high) else $error("high strobe moved in min");
  property p_min_unused;
    (settled && !max_reg && !strobe_low_group) |-> disp_data[7:5] == 3'h0 && !disp_data[0];
  endproperty
  a_min_unused: assert property (p_min_unused) else $error("unused line driven in min");
  property p_test_start; $rose(mode_load_n) |=> led_test_active; endproperty
  a_test_start: assert property (p_test_start) else $error("test did not start");
  property p_test_len;
    ($fell(led_test_active) && mode_load_n && $past(mode_load_n)) |-> cnt_reg == LED_TEST_CYCLES;
  endproperty
  a_test_len: assert property (p_test_len) else $error("test length wrong");
  property p_inhibit; repeat_inhibit == led_test_active; endproperty
  a_inhibit: assert property (p_inhibit) else $error("repeat not held off in test");
  property p_min_test; (led_test_active && settled && !max_reg && !strobe_low_group) |-> disp_data == 8'h1e;
  endproperty
  a_min_test: assert property (p_min_test) else $error("min test lamps wrong");
  property p_max_test;
    (led_test_active && settled && max_reg && !strobe_low_group)
      |-> disp_data[4:0] == (disp_data[7:5] == 3'h0 ? 5'h0e : 5'h1f);
  endproperty
  a_max_test: assert property (p_max_test) else $error("max test lamps wrong");
  property p_rti; s_rti_held |-> strobe_low_group && strobe_high_group; endproperty
  a_rti: assert property (p_rti) else $error("scan ran during interrupt");
endmodule // lsd_display_assertions
bind lsd_display lsd_display_assertions #(.LED_TEST_CYCLES(LED_TEST_CYCLES)) u_lsd_display_assertions (
  .clk(clk), .rstn(rstn), .ce(ce), .mode_load_n(mode_load_n), .mode_cfg_max(mode_cfg_max),
  .realtime_interrupt(realtime_interrupt), .disp_data(disp_data), .strobe_low_group(strobe_low_group),
  .strobe_high_group(strobe_high_group), .repeat_inhibit(repeat_inhibit), .led_test_active(led_test_active));

//--- lsd_latch_model.sv
// Purpose: external addressable latches behind the display pins
// Assumes: strobes active low
// Notes: bits are unknown until first loaded, as on real parts
`timescale 1ns/1ns
module lsd_latch_model (
  input wire logic strobe_low_group,
  input wire logic strobe_high_group,
  input wire logic [7:0] disp_data,
  output logic [4:0] lo_q [8],
  output logic [4:0] hi_q [8]
);
  // transparent while enabled, holds otherwise
  always @(strobe_low_group or strobe_high_group or disp_data) begin
    if (!strobe_low_group) lo_q[disp_data[7:5]] = disp_data[4:0];
    if (!strobe_high_group) hi_q[disp_data[7:5]] = disp_data[4:0];
  end
endmodule // lsd_latch_model

//--- test_led_status_display_update.sv
// Purpose: self-checking bench for the status display update logic
// Assumes: short test and freeze counts
// Notes: lamp results are read from the latch model, as the lamps would show them
`timescale 1ns/1ns
module test_led_status_display_update;
  import lsd_pkg::*;
  localparam int unsigned LT = 200;
  localparam int unsigned FZ = 400;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic mode_load_n = 1'b1;
  logic mode_cfg_max = 1'b0;
  logic realtime_interrupt = 1'b0;
  logic repeat_active = 1'b0;
  logic jabber_active = 1'b0;
  lsd_port_vec_t port_link = 13'h0, port_col = 13'h0, port_rec = 13'h0;
  lsd_port_vec_t port_part = 13'h0, port_bad_pol = 13'h0, port_internal_tp = 13'h0;
  logic [7:0] disp_data;
  logic strobe_low_group, strobe_high_group, repeat_inhibit, led_test_active;
  logic [4:0] lo_q [8];
  logic [4:0] hi_q [8];
  int mismatches = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  lsd_display #(.LED_TEST_CYCLES(LT), .FREEZE_CYCLES(FZ)) u_lsd_display (.clk(clk), .rstn(rstn), .ce(ce),
    .mode_load_n(mode_load_n), .mode_cfg_max(mode_cfg_max), .realtime_interrupt(realtime_interrupt),
    .repeat_active(repeat_active), .jabber_active(jabber_active), .port_link(port_link), .port_col(port_col),
    .port_rec(port_rec), .port_part(port_part), .port_bad_pol(port_bad_pol), .port_internal_tp(port_internal_tp),
    .disp_data(disp_data), .strobe_low_group(strobe_low_group), .strobe_high_group(strobe_high_group),
    .repeat_inhibit(repeat_inhibit), .led_test_active(led_test_active));
  lsd_latch_model u_lsd_latch_model (.strobe_low_group(strobe_low_group),
    .strobe_high_group(strobe_high_group), .disp_data(disp_data), .lo_q(lo_q), .hi_q(hi_q));
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [4:0] exp_port(input int p);
    return {port_bad_pol[p] & port_internal_tp[p], port_part[p], port_rec[p], port_col[p],
      port_link[p] & port_internal_tp[p]};
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic load_mode(input logic mx);
    int n;
    @(posedge clk);
    mode_load_n <= 1'b0;
    mode_cfg_max <= mx;
    tick(3);
    mode_load_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h0, led_test_active}, 8'h1);
    chk({7'h0, repeat_inhibit}, 8'h1);
    n = 0;
    while (led_test_active === 1'b1 && n < LT + 10) begin
      @(negedge clk);
      n++;
    end
    chk(n[7:0], LT[7:0]);
  endtask
  task automatic t_min;
    @(posedge clk);
    port_col <= 13'h0004;
    jabber_active <= 1'b1;
    port_part <= 13'h0100;
    tick(40);
    @(negedge clk);
    chk({3'h0, lo_q[0]}, 8'h1a);
    chk({7'h0, strobe_high_group}, 8'h1);
  endtask
  task automatic t_max;
    @(posedge clk);
    port_link <= 13'h1555;
    port_col <= 13'h0a0a;
    port_rec <= 13'h00f0;
    port_part <= 13'h1003;
    port_bad_pol <= 13'h1fff;
    port_internal_tp <= 13'h0fff;
    tick(300);
    @(negedge clk);
    chk({3'h0, lo_q[0]}, {4'h0, jabber_active, |port_rec, |port_col, 1'b0});
    for (int p = 1; p < 14; p++)
      chk({3'h0, p < 8 ? lo_q[p] : hi_q[p - 8]}, {3'h0, exp_port(p)});
  endtask
  task automatic t_ce;
    logic [7:0] d;
    logic sl;
    logic sh;
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    d = disp_data;
    sl = strobe_low_group;
    sh = strobe_high_group;
    tick(30);
    @(negedge clk);
    chk(disp_data, d);
    chk({6'h0, strobe_low_group, strobe_high_group}, {6'h0, sl, sh});
    @(posedge clk);
    ce <= 1'b1;
  endtask
  task automatic t_rti;
    int n;
    @(posedge clk);
    realtime_interrupt <= 1'b1;
    tick(12);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (!(strobe_low_group && strobe_high_group)) n++;
    end
    chk(n[7:0], 8'h0);
    @(posedge clk);
    realtime_interrupt <= 1'b0;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (!(strobe_low_group && strobe_high_group)) n++;
    end
    chk({7'h0, n > 0}, 8'h1);
  endtask
  task automatic t_freeze(input logic early_end);
    @(posedge clk);
    port_rec <= 13'h0002;
    repeat_active <= 1'b1;
    tick(150);
    repeat_active <= 1'b0;
    tick(3);
    port_rec <= 13'h0;
    tick(20);
    repeat_active <= early_end;
    tick(200);
    @(negedge clk);
    chk({7'h0, lo_q[2][2]}, {7'h0, !early_end});
    tick(FZ);
    @(negedge clk);
    chk({7'h0, lo_q[2][2]}, 8'h0);
    @(posedge clk);
    repeat_active <= 1'b0;
  endtask
  initial begin
    tick(10);
    rstn <= 1'b1;
    load_mode(1'b0);
    t_min;
    load_mode(1'b1);
    t_max;
    t_ce;
    t_rti;
    t_freeze(1'b0);
    t_freeze(1'b1);
    finish_test;
  end
endmodule // test_led_status_display_update
